/* File: bench/ctrl_model.sv */
// safety controller model: bus master, activity level and log strobe
`timescale 1ns/1ps
module ctrl_model #(
  parameter logic [6:0] DEV_ADDR = seq_fault_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic       clk_in,        // system clock
  input  wire logic       sda_wire_in,   // resolved data line
  output logic            scl_out,       // bus clock
  output logic            sda_drv_out,   // 0 pulls data low, 1 releases
  output logic            act_out,       // activity level
  output logic [7:0]      log_order_out, // logged order value
  output logic            log_valid_out, // one-cycle log strobe
  output logic            pec_en_out     // check byte in use
);
  ////////////////////////////////////////
  // bus idle, active mode, no check byte
  initial begin
    scl_out = 1'h1;
    sda_drv_out = 1'h1;
    act_out = 1'h1;
    log_order_out = 8'h00;
    log_valid_out = 1'h0;
    pec_en_out = 1'h0;
  end
  // crc-8, poly 07, one byte
  function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
    end
    return r;
  endfunction
  // three clocks a phase, well above the two-clock minimum
  task automatic half();
    repeat (3) @(posedge clk_in);
    #2;
  endtask
  // start, also used as repeated start
  task automatic start();
    sda_drv_out = 1'h1;
    half();
    scl_out = 1'h1;
    half();
    sda_drv_out = 1'h0;
    half();
    scl_out = 1'h0;
    half();
  endtask
  task automatic stop();
    sda_drv_out = 1'h0;
    half();
    scl_out = 1'h1;
    half();
    sda_drv_out = 1'h1;
    half();
  endtask
  // byte out msb first, acknowledge sampled with clock high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv_out = b[i];
      half();
      scl_out = 1'h1;
      half();
      scl_out = 1'h0;
    end
    sda_drv_out = 1'h1;
    half();
    scl_out = 1'h1;
    half();
    ack = ~sda_wire_in;
    scl_out = 1'h0;
  endtask
  // byte in, then nack to end the read
  task automatic get_byte(output logic [7:0] b);
    sda_drv_out = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      half();
      scl_out = 1'h1;
      half();
      b[i] = sda_wire_in;
      scl_out = 1'h0;
    end
    half();
    scl_out = 1'h1;
    half();
    scl_out = 1'h0;
  endtask
  // mode: 0 plain, 1 good check, 2 bad check, 3 good check plus extra byte
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d, input int mode,
                           output logic ack);
    logic [7:0] c;
    logic       a;
    c = crc_add(crc_add(crc_add(8'h00, {DEV_ADDR, 1'h0}), ofs), d);
    start();
    put_byte({DEV_ADDR, 1'h0}, ack);
    put_byte(ofs, a);
    ack = ack & a;
    put_byte(d, a);
    ack = ack & a;
    if (mode != 0) begin
      put_byte(mode == 2 ? ~c : c, a);
      ack = ack & a;
    end
    if (mode == 3) begin
      put_byte(8'h00, a);
    end
    stop();
  endtask
  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start();
    put_byte({DEV_ADDR, 1'h0}, a);
    put_byte(ofs, a);
    start();
    put_byte({DEV_ADDR, 1'h1}, a);
    get_byte(d);
    stop();
  endtask
  // activity level, changed just after an edge
  task automatic set_act(input logic v);
    @(posedge clk_in);
    #2;
    act_out = v;
  endtask
  // one strobe; value turns over afterwards, not left lingering
  task automatic log_strobe(input logic [7:0] v);
    @(posedge clk_in);
    #2;
    log_order_out = v;
    log_valid_out = 1'h1;
    @(posedge clk_in);
    #2;
    log_valid_out = 1'h0;
    log_order_out = ~v;
  endtask
  // check byte on or off, changed just after an edge
  task automatic set_pec(input logic v);
    @(posedge clk_in);
    #2;
    pec_en_out = v;
  endtask
endmodule

/* File: bench/sleep_entry_check_fault_latch_tb.sv */
// testbench: register access, sleep-entry check and fault latch
`timescale 1ns/1ps
module sleep_entry_check_fault_latch_tb;
  logic       clk_in = 1'h0;
  logic       reset_n_in = 1'h0;
  logic       scl, sda_drv, act, log_v, pec_en;
  logic       sda_out, sda_oe_n, irq_val, irq_oe_n, act_mode;
  logic [7:0] log_order, rd;
  logic       sda_wire; // pulled up, low while either side pulls
  logic       ack;
  int         error_cnt = 0;
  int         compares = 0;
  int         cycles = 0;
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  always #12.5 clk_in = ~clk_in;
  sleep_entry_check_fault_latch u_sleep_entry_check_fault_latch (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .activity_input_in(act),
    .sleep_entry_logged_order_ch6_in(log_order), .log_valid_ch6_in(log_v),
    .pec_enable_in(pec_en), .fault_interrupt_n_out(irq_val),
    .fault_interrupt_n_oe_n_out(irq_oe_n), .active_mode_out(act_mode));
  ctrl_model u_ctrl_model (
    .clk_in(clk_in), .sda_wire_in(sda_wire), .scl_out(scl), .sda_drv_out(sda_drv),
    .act_out(act), .log_order_out(log_order), .log_valid_out(log_v), .pec_en_out(pec_en));
  ////////////////////////////////////////
  // hang guard, well above the run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    u_ctrl_model.reg_read(ofs, rd);
    chk($sformatf("reg %h", ofs), exp, rd);
  endtask
  // write, every byte except the mode 3 extra byte must be acknowledged
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input int mode);
    u_ctrl_model.reg_write(ofs, d, mode, ack);
    chk("write ack", 8'h01, {7'h00, ack});
  endtask
  // pin is looked at n edges on, after the edge settles
  task automatic irq_chk(input int n, input logic exp);
    repeat (n) @(posedge clk_in);
    #2;
    chk("interrupt enable", {7'h00, exp}, {7'h00, irq_oe_n});
    // resolved line: pulled up while released, else the driven level
    chk("interrupt pin", {7'h00, exp}, {7'h00, irq_oe_n | irq_val});
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_in);
    #2;
    reset_n_in = 1'h1;
    rd_chk(seq_fault_pkg::EXP_ORDER_CH6_OFS, seq_fault_pkg::EXP_ORDER_RST);
    rd_chk(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h00);
    rd_chk(seq_fault_pkg::MODE_STAT_OFS, 8'h01);
    wr(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'hA5, 0);
    rd_chk(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'hA5);
    wr(8'h20, 8'h77, 0);
    rd_chk(8'h20, 8'h00);
    $display("test registers done");
    // sleep entry with the expected order: no fault
    u_ctrl_model.set_act(1'h0);
    irq_chk(2, 1'h1);
    chk("active mode", 8'h00, {7'h00, act_mode});
    rd_chk(seq_fault_pkg::MODE_STAT_OFS, 8'h00);
    u_ctrl_model.log_strobe(8'hA5);
    irq_chk(3, 1'h1);
    rd_chk(seq_fault_pkg::LOG_ORDER_CH6_OFS, 8'hA5);
    // second sleep entry with a wrong order
    u_ctrl_model.set_act(1'h1);
    irq_chk(2, 1'h1);
    chk("active mode", 8'h01, {7'h00, act_mode});
    u_ctrl_model.set_act(1'h0);
    repeat (2) @(posedge clk_in);
    u_ctrl_model.log_strobe(8'h3C);
    irq_chk(0, 1'h1);
    irq_chk(1, 1'h0);
    u_ctrl_model.set_act(1'h1);
    u_ctrl_model.log_strobe(8'hA5);
    irq_chk(4, 1'h0);
    rd_chk(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h01);
    wr(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h00, 0);
    rd_chk(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h01);
    irq_chk(1, 1'h0);
    wr(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h01, 0);
    rd_chk(seq_fault_pkg::INT_STAT_ONE_OFS, 8'h00);
    irq_chk(1, 1'h1);
    $display("test sequence done");
    // check byte faults
    u_ctrl_model.set_pec(1'h1);
    wr(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'h5A, 2);
    irq_chk(2, 1'h0);
    rd_chk(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'hA5);
    rd_chk(seq_fault_pkg::INT_STAT_TWO_OFS, 8'h01);
    wr(seq_fault_pkg::INT_STAT_TWO_OFS, 8'h01, 1);
    rd_chk(seq_fault_pkg::INT_STAT_TWO_OFS, 8'h00);
    wr(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'h5A, 1);
    rd_chk(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'h5A);
    irq_chk(1, 1'h1);
    wr(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'hC3, 3);
    rd_chk(seq_fault_pkg::EXP_ORDER_CH6_OFS, 8'h5A);
    rd_chk(seq_fault_pkg::INT_STAT_TWO_OFS, 8'h02);
    irq_chk(1, 1'h0);
    wr(seq_fault_pkg::INT_STAT_TWO_OFS, 8'h02, 1);
    irq_chk(2, 1'h1);
    $display("test check byte done");
    end_of_test();
  end
endmodule

/* File: src/seq_fault_pkg.sv */
// shared constants for the sleep-entry order check and fault latch
package seq_fault_pkg;

  // register map, byte offsets on the serial bus
  localparam logic [7:0] EXP_ORDER_CH6_OFS  = 8'hE5; // expected sleep-entry order, ch6
  localparam logic [7:0] INT_STAT_ONE_OFS   = 8'h10; // sticky sequence faults
  localparam logic [7:0] INT_STAT_TWO_OFS   = 8'h11; // sticky bus integrity faults
  localparam logic [7:0] LOG_ORDER_CH6_OFS  = 8'h12; // logged sleep-entry order, ch6
  localparam logic [7:0] MODE_STAT_OFS      = 8'h13; // bit 0 shows active mode

  // reset values
  localparam logic [7:0] EXP_ORDER_RST      = 8'h00;
  localparam logic [7:0] LOG_ORDER_RST      = 8'h00;

  // packet error check: crc-8, seeded with zero
  localparam logic [7:0] CRC_POLY           = 8'h07;
  localparam logic [7:0] CRC_INIT           = 8'h00;

  // strap-selected bus address; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT   = 7'h30;

  // sticky flag indices and their bit positions in the status registers
  localparam int         NUM_FLAGS          = 3;
  localparam int         FLAG_SEQ           = 0;
  localparam int         FLAG_PEC           = 1;
  localparam int         FLAG_EXTRA         = 2;
  localparam int         STAT_ONE_SEQ_BIT   = 0;
  localparam int         STAT_TWO_PEC_BIT   = 0;
  localparam int         STAT_TWO_EXTRA_BIT = 1;

  // position of a byte inside one bus transaction
  localparam logic [2:0] BYTE_ADDR          = 3'h0;
  localparam logic [2:0] BYTE_REG           = 3'h1;
  localparam logic [2:0] BYTE_DATA          = 3'h2;
  localparam logic [2:0] BYTE_PEC           = 3'h3;
  localparam logic [2:0] BYTE_EXTRA         = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_RACK = 3'b100
  } i2c_state_e;

endpackage

/* File: src/sleep_entry_check_fault_latch.sv */
// ch6 sleep-entry order check, serial register slave and latched fault interrupt
`timescale 1ns/1ps
module sleep_entry_check_fault_latch #(
  parameter logic [6:0] DEV_ADDR = seq_fault_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       scl_in,                        // bus clock, sampled
  input  wire logic       sda_in,                        // bus data level
  output logic            sda_out,                       // open-drain, always low
  output logic            sda_oe_n_out,                  // low while pulling data low
  input  wire logic       activity_input_in,             // high active, low sleep
  input  wire logic [7:0] sleep_entry_logged_order_ch6_in,
  input  wire logic       log_valid_ch6_in,              // logged order strobe
  input  wire logic       pec_enable_in,                 // check byte required
  output logic            fault_interrupt_n_out,         // open-drain, always low
  output logic            fault_interrupt_n_oe_n_out,    // low while interrupt asserted
  output logic            active_mode_out                // current mode
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  seq_fault_pkg::i2c_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;            // bits of current byte
  logic [2:0] byte_cnt_ff, nxt_byte_cnt;          // byte position, saturates
  logic [7:0] shift_ff, nxt_shift;                // receive shifter
  logic [7:0] tx_ff, nxt_tx;                      // transmit shifter
  logic [7:0] ptr_ff, nxt_ptr;                    // register pointer
  logic [7:0] hold_ff, nxt_hold;                  // data awaiting check byte
  logic [7:0] crc_ff, nxt_crc;                    // running check value
  logic       is_read_ff, nxt_is_read;
  logic       ack_ok_ff, nxt_ack_ok;
  logic       pending_ff, nxt_pending;            // checked write waits for stop
  logic       sda_drive_ff, nxt_sda_drive;
  logic       scl_q_ff, sda_q_ff;                 // previous bus levels
  logic       scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rx_byte;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       pec_bad, extra_bad;
  logic [7:0] rd_value;

  logic [7:0] exp_order_ff, nxt_exp_order;        // expected order, ch6
  logic [7:0] log_order_ff, nxt_log_order;        // last logged order, ch6
  logic       act_q_ff, nxt_act_q;
  logic       armed_ff, nxt_armed;                // sleep-entry sequence open
  logic       irq_ff, nxt_irq;
  logic       seq_mismatch;

  logic [seq_fault_pkg::NUM_FLAGS-1:0] flag_set, flag_clr, flags;

  ////////////////////////////////////////////////////////////////////////
  // check-byte step over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ seq_fault_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // readback mux; unmapped pointers read zero
  always_comb begin
    rd_value = 8'h00;
    case (ptr_ff)
      seq_fault_pkg::EXP_ORDER_CH6_OFS: rd_value = exp_order_ff;
      seq_fault_pkg::INT_STAT_ONE_OFS:
        rd_value[seq_fault_pkg::STAT_ONE_SEQ_BIT] = flags[seq_fault_pkg::FLAG_SEQ];
      seq_fault_pkg::INT_STAT_TWO_OFS: begin
        rd_value[seq_fault_pkg::STAT_TWO_PEC_BIT]   = flags[seq_fault_pkg::FLAG_PEC];
        rd_value[seq_fault_pkg::STAT_TWO_EXTRA_BIT] = flags[seq_fault_pkg::FLAG_EXTRA];
      end
      seq_fault_pkg::LOG_ORDER_CH6_OFS: rd_value = log_order_ff;
      seq_fault_pkg::MODE_STAT_OFS:     rd_value[0] = act_q_ff;
      default:                          rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // serial slave: sample on scl rise, change data on scl fall
  always_comb begin
    nxt_state     = state_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_byte_cnt  = byte_cnt_ff;
    nxt_shift     = shift_ff;
    nxt_tx        = tx_ff;
    nxt_ptr       = ptr_ff;
    nxt_hold      = hold_ff;
    nxt_crc       = crc_ff;
    nxt_is_read   = is_read_ff;
    nxt_ack_ok    = ack_ok_ff;
    nxt_pending   = pending_ff;
    nxt_sda_drive = sda_drive_ff;
    wr_en         = 1'b0;
    wr_data       = hold_ff;
    pec_bad       = 1'b0;
    extra_bad     = 1'b0;
    rx_byte       = {shift_ff[6:0], sda_in};
    scl_rise      = scl_in & ~scl_q_ff;
    scl_fall      = ~scl_in & scl_q_ff;
    bus_start     = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    bus_stop      = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    if (bus_stop) begin
      // checked write lands only at a clean stop
      nxt_state     = seq_fault_pkg::ST_IDLE;
      nxt_sda_drive = 1'b0;
      nxt_pending   = 1'b0;
      wr_en         = pending_ff;
    end else if (bus_start) begin
      // also covers repeated start
      nxt_state     = seq_fault_pkg::ST_RECV;
      nxt_bit_cnt   = 4'h0;
      nxt_byte_cnt  = seq_fault_pkg::BYTE_ADDR;
      nxt_crc       = seq_fault_pkg::CRC_INIT;
      nxt_is_read   = 1'b0;
      nxt_pending   = 1'b0;
      nxt_sda_drive = 1'b0;
    end else begin
      case (state_ff)
        seq_fault_pkg::ST_RECV: begin
          if (scl_rise && bit_cnt_ff < seq_fault_pkg::BITS_PER_BYTE) begin
            nxt_shift   = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == seq_fault_pkg::BITS_PER_BYTE - 4'h1) begin
              // whole byte in
              nxt_ack_ok = 1'b1;
              nxt_crc    = crc8(crc_ff, rx_byte);
              if (byte_cnt_ff != seq_fault_pkg::BYTE_EXTRA) begin
                nxt_byte_cnt = byte_cnt_ff + 3'h1;
              end
              case (byte_cnt_ff)
                seq_fault_pkg::BYTE_ADDR: begin
                  nxt_ack_ok  = (rx_byte[7:1] == DEV_ADDR);
                  nxt_is_read = rx_byte[0];
                end
                seq_fault_pkg::BYTE_REG: nxt_ptr = rx_byte;
                seq_fault_pkg::BYTE_DATA: begin
                  nxt_hold = rx_byte;
                  if (!pec_enable_in) begin
                    wr_en   = 1'b1;
                    wr_data = rx_byte;
                  end
                end
                seq_fault_pkg::BYTE_PEC: begin
                  // wrong check byte raises a fault, write dropped
                  if (pec_enable_in) begin
                    if (rx_byte == crc_ff) begin
                      nxt_pending = 1'b1;
                    end else begin
                      pec_bad = 1'b1;
                    end
                  end
                end
                default: begin
                  // byte after a good check byte fails the write
                  if (pec_enable_in) begin
                    extra_bad   = 1'b1;
                    nxt_pending = 1'b0;
                  end
                end
              endcase
            end
          end else if (scl_fall && bit_cnt_ff == seq_fault_pkg::BITS_PER_BYTE) begin
            nxt_state     = seq_fault_pkg::ST_ACK;
            nxt_bit_cnt   = 4'h0;
            nxt_sda_drive = ack_ok_ff;
          end
        end
        seq_fault_pkg::ST_ACK: begin
          if (scl_fall) begin
            nxt_sda_drive = 1'b0;
            if (!ack_ok_ff) begin
              nxt_state = seq_fault_pkg::ST_IDLE;  // not ours, wait for start
            end else if (is_read_ff) begin
              nxt_state     = seq_fault_pkg::ST_SEND;
              nxt_tx        = rd_value;
              nxt_sda_drive = ~rd_value[7];
            end else begin
              nxt_state = seq_fault_pkg::ST_RECV;
            end
          end
        end
        seq_fault_pkg::ST_SEND: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == seq_fault_pkg::BITS_PER_BYTE) begin
              nxt_state     = seq_fault_pkg::ST_RACK;
              nxt_bit_cnt   = 4'h0;
              nxt_sda_drive = 1'b0;
            end else begin
              nxt_tx        = {tx_ff[6:0], 1'b0};
              nxt_sda_drive = ~tx_ff[6];
            end
          end
        end
        seq_fault_pkg::ST_RACK: begin
          // master ack repeats the same register, no auto-increment
          if (scl_rise) begin
            nxt_ack_ok = ~sda_in;
          end else if (scl_fall) begin
            if (ack_ok_ff) begin
              nxt_state     = seq_fault_pkg::ST_SEND;
              nxt_tx        = rd_value;
              nxt_sda_drive = ~rd_value[7];
            end else begin
              nxt_state = seq_fault_pkg::ST_IDLE;
            end
          end
        end
        default: nxt_state = seq_fault_pkg::ST_IDLE;
      endcase
    end
  end

  // serial slave registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff     <= seq_fault_pkg::ST_IDLE;
      bit_cnt_ff   <= 4'h0;
      byte_cnt_ff  <= 3'h0;
      shift_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      ptr_ff       <= 8'h00;
      hold_ff      <= 8'h00;
      crc_ff       <= 8'h00;
      is_read_ff   <= 1'b0;
      ack_ok_ff    <= 1'b0;
      pending_ff   <= 1'b0;
      sda_drive_ff <= 1'b0;
      scl_q_ff     <= 1'b1;
      sda_q_ff     <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      bit_cnt_ff   <= nxt_bit_cnt;
      byte_cnt_ff  <= nxt_byte_cnt;
      shift_ff     <= nxt_shift;
      tx_ff        <= nxt_tx;
      ptr_ff       <= nxt_ptr;
      hold_ff      <= nxt_hold;
      crc_ff       <= nxt_crc;
      is_read_ff   <= nxt_is_read;
      ack_ok_ff    <= nxt_ack_ok;
      pending_ff   <= nxt_pending;
      sda_drive_ff <= nxt_sda_drive;
      scl_q_ff     <= scl_in;
      sda_q_ff     <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode, sequence check, expected order and interrupt latch
  always_comb begin
    nxt_act_q     = activity_input_in;
    nxt_exp_order = exp_order_ff;
    nxt_log_order = log_order_ff;
    nxt_armed     = armed_ff;
    nxt_irq       = |flags;
    if (wr_en && ptr_ff == seq_fault_pkg::EXP_ORDER_CH6_OFS) begin
      nxt_exp_order = wr_data;
    end
    if (log_valid_ch6_in) begin
      nxt_log_order = sleep_entry_logged_order_ch6_in;
    end
    // window opens on the active-to-sleep edge, closes on wake or log
    if (activity_input_in) begin
      nxt_armed = 1'b0;
    end else if (act_q_ff) begin
      nxt_armed = 1'b1;
    end else if (log_valid_ch6_in) begin
      nxt_armed = 1'b0;
    end
  end

  // a log strobe outside the window is stored but not judged
  assign seq_mismatch = armed_ff & log_valid_ch6_in &
                        (sleep_entry_logged_order_ch6_in != exp_order_ff);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_q_ff     <= 1'b0;
      exp_order_ff <= seq_fault_pkg::EXP_ORDER_RST;
      log_order_ff <= seq_fault_pkg::LOG_ORDER_RST;
      armed_ff     <= 1'b0;
      irq_ff       <= 1'b0;
    end else begin
      act_q_ff     <= nxt_act_q;
      exp_order_ff <= nxt_exp_order;
      log_order_ff <= nxt_log_order;
      armed_ff     <= nxt_armed;
      irq_ff       <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags, write-one-to-clear through the status registers
  assign flag_set[seq_fault_pkg::FLAG_SEQ]   = seq_mismatch;
  assign flag_set[seq_fault_pkg::FLAG_PEC]   = pec_bad;
  assign flag_set[seq_fault_pkg::FLAG_EXTRA] = extra_bad;
  assign flag_clr[seq_fault_pkg::FLAG_SEQ]   = wr_en & (ptr_ff == seq_fault_pkg::INT_STAT_ONE_OFS)
                                             & wr_data[seq_fault_pkg::STAT_ONE_SEQ_BIT];
  assign flag_clr[seq_fault_pkg::FLAG_PEC]   = wr_en & (ptr_ff == seq_fault_pkg::INT_STAT_TWO_OFS)
                                             & wr_data[seq_fault_pkg::STAT_TWO_PEC_BIT];
  assign flag_clr[seq_fault_pkg::FLAG_EXTRA] = wr_en & (ptr_ff == seq_fault_pkg::INT_STAT_TWO_OFS)
                                             & wr_data[seq_fault_pkg::STAT_TWO_EXTRA_BIT];

  for (genvar g = 0; g < seq_fault_pkg::NUM_FLAGS; g++) begin : gen_flag
    w1c_flag_bit u_flag (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .set_in     (flag_set[g]),
      .clr_in     (flag_clr[g]),
      .flag_out   (flags[g])
    );
  end

  // open-drain pins: data level fixed low, enable does the work
  assign sda_out                    = 1'b0;
  assign sda_oe_n_out               = ~sda_drive_ff;
  assign fault_interrupt_n_out      = 1'b0;
  assign fault_interrupt_n_oe_n_out = ~irq_ff;
  assign active_mode_out            = act_q_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_flag_then_pin(int idx);
    flags[idx] ##1 !fault_interrupt_n_oe_n_out;
  endsequence

  a_order_reg_write: assert property (
    wr_en && ptr_ff == seq_fault_pkg::EXP_ORDER_CH6_OFS |=> exp_order_ff == $past(wr_data))
    else $error("expected order write not stored");
  a_seq_compare: assert property (
    armed_ff && log_valid_ch6_in && sleep_entry_logged_order_ch6_in != exp_order_ff
    |=> s_flag_then_pin(seq_fault_pkg::FLAG_SEQ))
    else $error("order mismatch did not raise fault");
  a_match_quiet: assert property (
    !flags[seq_fault_pkg::FLAG_SEQ] && !seq_mismatch |=> !flags[seq_fault_pkg::FLAG_SEQ])
    else $error("sequence flag set without mismatch");
  a_mode_follow: assert property (
    activity_input_in |=> active_mode_out ##1 (active_mode_out == $past(activity_input_in)))
    else $error("mode does not follow activity input");
  a_irq_latched: assert property (
    !fault_interrupt_n_oe_n_out && |flags |=> !fault_interrupt_n_oe_n_out)
    else $error("interrupt released while a flag stands");
  a_w1c_clear: assert property (
    flag_clr[seq_fault_pkg::FLAG_SEQ] && !flag_set[seq_fault_pkg::FLAG_SEQ]
    |=> !flags[seq_fault_pkg::FLAG_SEQ])
    else $error("write of one did not clear flag");
  a_flag_holds: assert property (
    flags[seq_fault_pkg::FLAG_PEC] && !flag_clr[seq_fault_pkg::FLAG_PEC]
    |=> flags[seq_fault_pkg::FLAG_PEC])
    else $error("flag cleared without a write");
  a_status_read: assert property (
    ptr_ff == seq_fault_pkg::INT_STAT_ONE_OFS
    |-> rd_value[seq_fault_pkg::STAT_ONE_SEQ_BIT] == flags[seq_fault_pkg::FLAG_SEQ])
    else $error("status readback differs from flag");
  a_pec_fault: assert property (
    pec_bad |=> s_flag_then_pin(seq_fault_pkg::FLAG_PEC))
    else $error("bad check byte did not assert interrupt");

endmodule

/* File: src/w1c_flag_bit.sv */
// one sticky status flag, cleared only by writing a one
`timescale 1ns/1ps
module w1c_flag_bit (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic set_in,     // fault event, one cycle
  input  wire logic clr_in,     // write of one to this bit
  output logic      flag_out
);

  logic flag_ff;
  logic nxt_flag;

  ////////////////////////////////////////////////////////////////////////
  // set beats clear so an event in the clearing cycle is never lost
  always_comb begin
    nxt_flag = flag_ff;
    if (set_in) begin
      nxt_flag = 1'b1;
    end else if (clr_in) begin
      nxt_flag = 1'b0;
    end
  end

  // no hardware path ever clears the flag on its own
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_out = flag_ff;

endmodule
